// ===== rtl/mmsl_defs.svh
// address, size and lock constants for the memory map security lock
`ifndef MMSL_DEFS_SVH
`define MMSL_DEFS_SVH
`define MMSL_PAIR_8K 16'h3FFF
`define MMSL_PAIR_16K 16'h7FFF
`define MMSL_PAIR_32K 16'hFFFF
`define MMSL_VEC_TOP 16'h007F
`define MMSL_PRAM_TOP 16'h03FF
`define MMSL_DRAM_TOP 16'h03FF
`define MMSL_HALF 8'h80
`define MMSL_BIT_LO 8'h20
`define MMSL_BIT_HI 8'h2F
`define MMSL_LOCK_ADDR 6'h00
`define MMSL_LOCK_SEC_ADDR 8'h40
`define MMSL_LOCK_LSB 3
`define MMSL_ERASED 8'hFF
`define MMSL_MISS_WAIT 2'h3
`define MMSL_HIT_WAIT 2'h1
`define MMSL_LOCK_OPEN 3'h7
`define MMSL_SIZE_RESET 2'h1
`define MMSL_LVL_1 2'h0
`define MMSL_LVL_2 2'h1
`define MMSL_LVL_3 2'h2
`define MMSL_LVL_4 2'h3
`define MMSL_REG_SIZE 8'h00
`define MMSL_REG_CTRL 8'h04
`define MMSL_REG_LOCK 8'h08
`define MMSL_REG_STAT 8'h0C
`endif

// ===== rtl/mmsl_pkg.sv
// types for the memory map security lock
package mmsl_pkg;
  typedef enum logic [1:0] {MMSL_SP_CODE, MMSL_SP_XDATA, MMSL_SP_IDIR, MMSL_SP_IIND} mmsl_space_t;
  typedef struct packed {
    logic req;
    logic wr;
    mmsl_space_t space;
    logic [15:0] addr;
    logic [7:0] wdata;
    logic from_ext;
    logic table_read;
    logic bit_op;
    logic [2:0] bit_sel;
    logic [1:0] bit_fn;
  } mmsl_req_t;
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] wdata;
    logic code_fetch_strobe_n;
    logic rd_n;
    logic wr_n;
  } mmsl_ext_t;
endpackage

// ===== rtl/mmsl_top.sv
// memory decode, scratchpad, external bus and lock enforcement
//
// The register addresses and the Avalon-MM slave port were chosen for this implementation.
`timescale 1ns/100ps
`include "mmsl_defs.svh"
// Summary of operation
// - accesses beyond enabled on-chip program or data memory go to the external bus.
// - external code fetch drives code fetch strobe low.
// - external data moves use read or write strobe; code fetches never do.
// - with nonzero code size, vectors come from lowest 128 bytes of on-chip flash.
// - 1kB data memory maps into program space when program ram enable set.
// - upper 128 internal bytes: indirect reaches scratchpad, direct reaches function registers.
// - lower 128 scratchpad bytes behave the same for direct and indirect.
// - four banks of eight working registers chosen by status word bank field.
// - bytes 20h to 2Fh support bit read, set, clear and test.
// - stack accesses use scratchpad at the stack pointer.
// - page mode 1 hits take one wait cycle; misses take three wait cycles.
// - flash is split into equal lower and upper banks of 8k, 16k or 32k.
// - after encryption array programmed, verify returns code XNOR key byte.
// - all lock bits one means no lock, verify still encrypted.
// - lock bit one cleared blocks external table reads, latches pin, refuses programming; the latch catches the synchronizer reset high, not the pin.
// - lock bit two cleared blocks verify and external reads of internal ram.
// - lock bit three cleared forbids execution from external memory.
// - lock bits only loosen through a mass erase.
// - lock bits sit at 40h of security block, returned on bits 5 to 3.
module mmsl_top (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire mmsl_pkg::mmsl_req_t cpu_req,
  input wire logic [7:0] sp_reg,
  input wire logic [1:0] bank_sel,
  input wire logic [2:0] reg_op,
  input wire logic reg_op_en,
  input wire logic stack_op,
  input wire logic [7:0] sfr_rdata,
  input wire logic [2:0] sec_lock_bits,
  input wire logic [7:0] sec_key_byte,
  input wire logic [7:0] flash_rdata,
  input wire logic verify_req,
  input wire logic [15:0] verify_addr,
  input wire logic prog_req,
  input wire logic ext_fetch_force_n,
  input wire logic [7:0] ext_rdata,
  output logic cpu_ack,
  output logic [7:0] cpu_rdata,
  output logic cpu_fault,
  output logic sfr_sel,
  output mmsl_pkg::mmsl_ext_t ext_bus,
  output logic [15:0] flash_addr,
  output logic [5:0] sec_key_addr,
  output logic [7:0] verify_data,
  output logic verify_ack,
  output logic prog_allow
);
  import mmsl_pkg::*;

  logic [7:0] iram [0:255];
  logic [7:0] xram [0:1023];
  logic [1:0] onchip_code_size_select_q;
  logic program_ram_enable_q;
  logic page_mode_one_q;
  logic mass_erase_q;
  logic [2:0] lock_q;
  logic key_prog_q;
  logic ea_s1_q, ea_s2_q, ea_latched_q, ea_taken_q;
  logic [7:0] page_q;
  logic page_vld_q;
  logic [1:0] wait_q;
  logic [1:0] avs_phase_q;
  logic [3:0] fault_cnt_q;
  logic lock_bit_one, lock_bit_two, lock_bit_three;
  logic [15:0] code_top;
  logic [7:0] iaddr;
  logic int_code, int_pram, int_xram, ext_access, blocked;
  logic fetch_ext_n;
  logic [1:0] sec_level;

  assign lock_bit_one = lock_q[0];
  assign lock_bit_two = lock_q[1];
  assign lock_bit_three = lock_q[2];

  // pin is asynchronous to clk
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ea_s1_q <= 1'b1;
      ea_s2_q <= 1'b1;
    end
    else
    begin
      ea_s1_q <= ext_fetch_force_n;
      ea_s2_q <= ea_s1_q;
    end
  end

  // lock latch, caught first clock after reset release
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      lock_q <= `MMSL_LOCK_OPEN;
      key_prog_q <= 1'b0;
      ea_latched_q <= 1'b1;
      ea_taken_q <= 1'b0;
    end
    else if (!ea_taken_q)
    begin
      lock_q <= sec_lock_bits;
      key_prog_q <= (sec_key_byte != `MMSL_ERASED);
      ea_latched_q <= ea_s2_q;
      ea_taken_q <= 1'b1;
    end
    else if (mass_erase_q)
      lock_q <= `MMSL_LOCK_OPEN;
    else
      lock_q <= lock_q & sec_lock_bits;
  end

  // one decode of the latched lock bits feeds every access check
  always_comb
  begin
    if (!lock_bit_three)
      sec_level = `MMSL_LVL_4;
    else if (!lock_bit_two)
      sec_level = `MMSL_LVL_3;
    else if (!lock_bit_one)
      sec_level = `MMSL_LVL_2;
    else
      sec_level = `MMSL_LVL_1;
  end

  assign fetch_ext_n = (sec_level == `MMSL_LVL_1) ? ea_s2_q : ea_latched_q;

  always_comb
  begin
    unique case (onchip_code_size_select_q)
      2'h0: code_top = 16'h0000;
      2'h1: code_top = `MMSL_PAIR_8K;
      2'h2: code_top = `MMSL_PAIR_16K;
      default: code_top = `MMSL_PAIR_32K;
    endcase
  end

  // register operand maps into selected bank
  always_comb
  begin
    if (reg_op_en)
      iaddr = {3'h0, bank_sel, reg_op};
    else if (stack_op)
      iaddr = sp_reg;
    else
      iaddr = cpu_req.addr[7:0];
  end

  always_comb
  begin
    int_code = 1'b0;
    if (onchip_code_size_select_q != 2'h0)
    begin
      // vectors stay on chip even while the pin forces external code
      if (cpu_req.addr <= `MMSL_VEC_TOP)
        int_code = 1'b1;
      else if (fetch_ext_n && cpu_req.addr <= code_top)
        int_code = 1'b1;
    end
    int_pram = program_ram_enable_q && (cpu_req.addr <= `MMSL_PRAM_TOP) && !int_code;
    int_xram = !program_ram_enable_q && (cpu_req.addr <= `MMSL_DRAM_TOP);
    ext_access = (cpu_req.space == MMSL_SP_CODE) ? !(int_code || int_pram) : (cpu_req.space == MMSL_SP_XDATA) && !int_xram;
    blocked = 1'b0;
    if (cpu_req.space == MMSL_SP_CODE && ext_access && !cpu_req.table_read && sec_level == `MMSL_LVL_4)
      blocked = 1'b1;
    if (cpu_req.table_read && cpu_req.from_ext && !ext_access && sec_level != `MMSL_LVL_1)
      blocked = 1'b1;
    if (cpu_req.space == MMSL_SP_XDATA && cpu_req.from_ext && !ext_access && sec_level >= `MMSL_LVL_3)
      blocked = 1'b1;
  end

  // external bus, page mode hit runs with one wait cycle, miss with three
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ext_bus <= '{addr: 16'h0000, wdata: 8'h00, code_fetch_strobe_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1};
      page_q <= 8'h00;
      page_vld_q <= 1'b0;
      wait_q <= 2'h0;
      cpu_ack <= 1'b0;
      cpu_fault <= 1'b0;
      cpu_rdata <= 8'h00;
      sfr_sel <= 1'b0;
      flash_addr <= 16'h0000;
      fault_cnt_q <= 4'h0;
    end
    else
    begin
      cpu_ack <= 1'b0;
      cpu_fault <= 1'b0;
      sfr_sel <= 1'b0;
      ext_bus.code_fetch_strobe_n <= 1'b1;
      ext_bus.rd_n <= 1'b1;
      ext_bus.wr_n <= 1'b1;
      if (wait_q != 2'h0)
      begin
        wait_q <= wait_q - 2'h1;
        ext_bus.code_fetch_strobe_n <= ext_bus.code_fetch_strobe_n;
        ext_bus.rd_n <= ext_bus.rd_n;
        ext_bus.wr_n <= ext_bus.wr_n;
        if (wait_q == 2'h1)
        begin
          cpu_ack <= 1'b1;
          cpu_rdata <= ext_rdata;
        end
      end
      else if (cpu_req.req && !cpu_ack)
      begin
        if (blocked)
        begin
          cpu_ack <= 1'b1;
          cpu_fault <= 1'b1;
          cpu_rdata <= `MMSL_ERASED;
          fault_cnt_q <= fault_cnt_q + 4'h1;
        end
        else if (ext_access)
        begin
          ext_bus.addr <= cpu_req.addr;
          ext_bus.wdata <= cpu_req.wdata;
          if (cpu_req.space == MMSL_SP_CODE)
            ext_bus.code_fetch_strobe_n <= 1'b0;
          else if (cpu_req.wr)
            ext_bus.wr_n <= 1'b0;
          else
            ext_bus.rd_n <= 1'b0;
          page_q <= cpu_req.addr[15:8];
          page_vld_q <= 1'b1;
          if (page_mode_one_q && page_vld_q && page_q == cpu_req.addr[15:8])
            wait_q <= `MMSL_HIT_WAIT;
          else
            wait_q <= `MMSL_MISS_WAIT;
        end
        else if (cpu_req.space == MMSL_SP_CODE && int_code)
        begin
          flash_addr <= cpu_req.addr;
          cpu_ack <= 1'b1;
          cpu_rdata <= flash_rdata;
        end
        else if (cpu_req.space == MMSL_SP_CODE || cpu_req.space == MMSL_SP_XDATA)
        begin
          cpu_ack <= 1'b1;
          cpu_rdata <= xram[cpu_req.addr[9:0]];
        end
        else if (cpu_req.space == MMSL_SP_IDIR && iaddr >= `MMSL_HALF && !stack_op && !reg_op_en)
        begin
          sfr_sel <= 1'b1;
          cpu_ack <= 1'b1;
          cpu_rdata <= sfr_rdata;
        end
        else
        begin
          cpu_ack <= 1'b1;
          if (cpu_req.bit_op && iaddr >= `MMSL_BIT_LO && iaddr <= `MMSL_BIT_HI)
            cpu_rdata <= {7'h00, iram[iaddr][cpu_req.bit_sel]};
          else
            cpu_rdata <= iram[iaddr];
        end
      end
    end
  end

  // memory writes, including bit set and clear
  always_ff @(posedge clk)
  begin
    if (rst_b && cpu_req.req && !cpu_ack && wait_q == 2'h0 && !blocked && !ext_access && cpu_req.wr)
    begin
      if (cpu_req.space == MMSL_SP_CODE || cpu_req.space == MMSL_SP_XDATA)
      begin
        if (cpu_req.space == MMSL_SP_XDATA || !int_code)
          xram[cpu_req.addr[9:0]] <= cpu_req.wdata;
      end
      else if (!(cpu_req.space == MMSL_SP_IDIR && iaddr >= `MMSL_HALF && !stack_op && !reg_op_en))
      begin
        if (cpu_req.bit_op && iaddr >= `MMSL_BIT_LO && iaddr <= `MMSL_BIT_HI)
          iram[iaddr][cpu_req.bit_sel] <= cpu_req.bit_fn[0];
        else
          iram[iaddr] <= cpu_req.wdata;
      end
    end
  end

  // verify path with encryption
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      verify_data <= 8'h00;
      verify_ack <= 1'b0;
      sec_key_addr <= 6'h00;
      prog_allow <= 1'b0;
    end
    else
    begin
      verify_ack <= verify_req && !verify_ack;
      sec_key_addr <= verify_addr[5:0];
      prog_allow <= prog_req && ea_taken_q && (sec_level == `MMSL_LVL_1);
      if (verify_req && !verify_ack)
      begin
        if (sec_level >= `MMSL_LVL_3)
          verify_data <= `MMSL_ERASED;
        else if (key_prog_q)
          verify_data <= ~(flash_rdata ^ sec_key_byte);
        else
          verify_data <= flash_rdata;
      end
    end
  end

  // avalon slave: two wait cycles then answer
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      avs_phase_q <= 2'h0;
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0000_0000;
      onchip_code_size_select_q <= `MMSL_SIZE_RESET;
      program_ram_enable_q <= 1'b0;
      page_mode_one_q <= 1'b0;
      mass_erase_q <= 1'b0;
    end
    else
    begin
      mass_erase_q <= 1'b0;
      avs_waitrequest <= 1'b1;
      avs_phase_q <= 2'h0;
      if ((avs_read || avs_write) && avs_phase_q == 2'h0)
        avs_phase_q <= 2'h1;
      else if (avs_phase_q == 2'h1)
      begin
        avs_waitrequest <= 1'b0;
        avs_phase_q <= 2'h2;
        avs_readdata <= 32'h0000_0000;
        if (avs_read)
        begin
          unique case (avs_address)
            `MMSL_REG_SIZE: avs_readdata <= {30'h0, onchip_code_size_select_q};
            `MMSL_REG_CTRL: avs_readdata <= {30'h0, page_mode_one_q, program_ram_enable_q};
            `MMSL_REG_LOCK: avs_readdata <= {26'h0, lock_q, 3'h0};
            `MMSL_REG_STAT: avs_readdata <= {22'h0, fault_cnt_q, key_prog_q, ea_latched_q, 4'h0};
            default: avs_readdata <= 32'h0000_0000;
          endcase
        end
      end
      // write lands only on the edge where the master sees waitrequest low
      else if (avs_phase_q == 2'h2 && avs_write && avs_byteenable[0])
      begin
        if (avs_address == `MMSL_REG_SIZE)
          onchip_code_size_select_q <= avs_writedata[1:0];
        else if (avs_address == `MMSL_REG_CTRL)
        begin
          program_ram_enable_q <= avs_writedata[0];
          page_mode_one_q <= avs_writedata[1];
          mass_erase_q <= avs_writedata[2];
        end
      end
    end
  end
endmodule

// ===== tb/mmsl_properties.sv
// concurrent checks on the memory map security lock ports
`timescale 1ns/100ps
module mmsl_properties (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire mmsl_pkg::mmsl_req_t cpu_req,
  input wire logic stack_op,
  input wire logic reg_op_en,
  input wire logic cpu_ack,
  input wire logic sfr_sel,
  input wire mmsl_pkg::mmsl_ext_t ext_bus,
  input wire logic [2:0] sec_lock_bits,
  input wire logic [7:0] sec_key_byte,
  input wire logic [7:0] flash_rdata,
  input wire logic [7:0] verify_data,
  input wire logic verify_ack,
  input wire logic prog_allow
);
  import mmsl_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // first edge of a request from on-chip code
  sequence s_new(mmsl_space_t s);
    $rose(cpu_req.req) && cpu_req.space == s && !cpu_req.from_ext;
  endsequence
  sequence s_lock_rd;
    $rose(avs_read) && avs_address == 8'h08;
  endsequence
  sequence s_answer;
    avs_waitrequest ##1 !avs_waitrequest;
  endsequence
  AST_XDATA_EXT: assert property (s_new(MMSL_SP_XDATA) ##0 (cpu_req.addr > 16'h03FF && !cpu_req.wr) |-> ##[1:2] !ext_bus.rd_n)
    else $error("no external read strobe");
  AST_CODE_EXT: assert property (s_new(MMSL_SP_CODE) ##0 (cpu_req.addr > 16'h3FFF && sec_lock_bits[2])
    |-> ##[1:2] !ext_bus.code_fetch_strobe_n)
    else $error("no code fetch strobe");
  AST_FETCH_NO_RW: assert property (!ext_bus.code_fetch_strobe_n |-> ext_bus.rd_n && ext_bus.wr_n)
    else $error("data strobe during fetch");
  AST_SFR_DIRECT: assert property (s_new(MMSL_SP_IDIR) ##0 (cpu_req.addr[7] && !stack_op && !reg_op_en && !cpu_req.wr)
    |-> ##[1:2] (sfr_sel && cpu_ack))
    else $error("direct upper access missed function registers");
  AST_NO_EXT_EXEC: assert property (!sec_lock_bits[2] |-> ext_bus.code_fetch_strobe_n)
    else $error("external fetch while locked");
  AST_VERIFY_BLOCK: assert property (verify_ack && !(sec_lock_bits[1] && sec_lock_bits[2]) |-> verify_data == 8'hFF)
    else $error("verify not blocked");
  AST_VERIFY_XNOR: assert property (verify_ack && sec_lock_bits[1] && sec_lock_bits[2]
    |-> verify_data == ~($past(flash_rdata) ^ $past(sec_key_byte)))
    else $error("verify data not encrypted");
  AST_PROG_LEVEL: assert property (prog_allow |-> sec_lock_bits == 3'h7)
    else $error("programming allowed while locked");
  AST_LOCK_READ: assert property (s_lock_rd |-> ##1 s_answer ##0 avs_readdata[5:3] == sec_lock_bits)
    else $error("lock bits misplaced");
endmodule

// ===== tb/mmsl_xmem.sv
// behavioural external program and data memory on the expanded bus
`timescale 1ns/100ps
module mmsl_xmem (
  input wire logic clk,
  input wire mmsl_pkg::mmsl_ext_t ext_bus,
  output logic [7:0] ext_rdata
);
  import mmsl_pkg::*;
  logic [7:0] mem_q [256];
  logic [7:0] last_q = 8'h00;
  // low address byte only, so code and data spaces alias
  always @(posedge clk)
  begin
    if (!ext_bus.wr_n)
      mem_q[ext_bus.addr[7:0]] <= ext_bus.wdata;
    last_q <= ext_rdata;
  end
  // released bus toggles, never holds a stale byte
  assign ext_rdata = (!ext_bus.rd_n || !ext_bus.code_fetch_strobe_n) ? mem_q[ext_bus.addr[7:0]] : ~last_q;
endmodule

// ===== tb/tb.sv
// self-checking bench for the memory map security lock
`timescale 1ns/100ps
module tb;
  import mmsl_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic avs_read = 1'b0, avs_write = 1'b0, reg_op_en = 1'b0, stack_op = 1'b0;
  logic verify_req = 1'b0, prog_req = 1'b0, ext_fetch_force_n = 1'b1;
  logic [7:0] avs_address = 8'h00, sp_reg = 8'h00, sfr_rdata = 8'h77, sec_key_byte = 8'hFF, flash_rdata = 8'h3C;
  logic [31:0] avs_writedata = 32'h0, avs_readdata;
  logic [3:0] avs_byteenable = 4'h0;
  logic [1:0] bank_sel = 2'h0;
  logic [2:0] reg_op = 3'h0, sec_lock_bits = 3'h7;
  logic [15:0] verify_addr = 16'h0000, flash_addr;
  mmsl_req_t cpu_req = '0;
  mmsl_ext_t ext_bus;
  logic avs_waitrequest, cpu_ack, cpu_fault, sfr_sel, verify_ack, prog_allow;
  logic [7:0] ext_rdata, cpu_rdata, verify_data;
  logic [5:0] sec_key_addr;
  int fails = 0, n_checks = 0, cyc = 0;
  mmsl_top dut_u (.clk, .rst_b, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
    .avs_readdata, .avs_waitrequest, .cpu_req, .sp_reg, .bank_sel, .reg_op, .reg_op_en, .stack_op,
    .sfr_rdata, .sec_lock_bits, .sec_key_byte, .flash_rdata, .verify_req, .verify_addr, .prog_req,
    .ext_fetch_force_n, .ext_rdata, .cpu_ack, .cpu_rdata, .cpu_fault, .sfr_sel, .ext_bus, .flash_addr,
    .sec_key_addr, .verify_data, .verify_ack, .prog_allow);
  mmsl_xmem xmem_u (.clk, .ext_bus, .ext_rdata);
  always #5 clk = ~clk;
  task automatic give_verdict;
    if (fails == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // a hang costs a mismatch, not an endless run
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      fails++;
      give_verdict();
    end
  end
  task automatic chk(input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("[ERR] t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask
  task automatic rst(input logic [2:0] lk, input logic [7:0] k);
    @(posedge clk);
    rst_b <= 1'b0;
    sec_lock_bits <= lk;
    sec_key_byte <= k;
    prog_req <= 1'b1;
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
  endtask
  task automatic avs(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    avs_read <= !w;
    avs_write <= w;
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= 4'h1;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  function automatic mmsl_req_t rq(mmsl_space_t s, logic [15:0] a, logic w, logic [7:0] d);
    rq = '0;
    rq.req = 1'b1;
    rq.space = s;
    rq.addr = a;
    rq.wr = w;
    rq.wdata = d;
  endfunction
  // one cpu access, judged on fault, and on read data for reads
  task automatic acc(input mmsl_req_t r, input logic [7:0] e, input logic ef);
    @(posedge clk);
    cpu_req <= r;
    do @(posedge clk); while (cpu_ack !== 1'b1);
    if (!r.wr)
      chk(e, cpu_rdata);
    chk(ef, cpu_fault);
    cpu_req <= '0;
  endtask
  task automatic ver(input logic [7:0] e);
    @(posedge clk);
    verify_req <= 1'b1;
    verify_addr <= 16'h0005;
    do @(posedge clk); while (verify_ack !== 1'b1);
    chk(e, verify_data);
    verify_req <= 1'b0;
  endtask
  task automatic t_regs;
    logic [31:0] q;
    avs(1'b0, 8'h08, 32'h0, q);
    chk(3'h7, q[5:3]);
    avs(1'b0, 8'h00, 32'h0, q);
    chk(2'h1, q[1:0]);
    avs(1'b1, 8'h40, 32'hFF, q);
    avs(1'b0, 8'h40, 32'h0, q);
    chk(32'h0, q);
  endtask
  task automatic t_ext;
    acc(rq(MMSL_SP_XDATA, 16'h1234, 1'b1, 8'hA5), 8'h00, 1'b0);
    acc(rq(MMSL_SP_XDATA, 16'h1234, 1'b0, 8'h00), 8'hA5, 1'b0);
    acc(rq(MMSL_SP_CODE, 16'hC034, 1'b0, 8'h00), 8'hA5, 1'b0);
    acc(rq(MMSL_SP_CODE, 16'h2010, 1'b0, 8'h00), 8'h3C, 1'b0);
    chk(16'h2010, flash_addr);
    ext_fetch_force_n <= 1'b0;
    repeat (3) @(posedge clk);
    acc(rq(MMSL_SP_CODE, 16'h0010, 1'b0, 8'h00), 8'h3C, 1'b0);
    chk(16'h0010, flash_addr);
    acc(rq(MMSL_SP_CODE, 16'h0834, 1'b0, 8'h00), 8'hA5, 1'b0);
    ext_fetch_force_n <= 1'b1;
    repeat (3) @(posedge clk);
  endtask
  // page miss first, then a hit on the same page
  task automatic t_page;
    logic [31:0] q;
    int n;
    avs(1'b1, 8'h04, 32'h2, q);
    for (int i = 0; i < 2; i++)
    begin
      @(posedge clk);
      cpu_req <= rq(MMSL_SP_XDATA, 16'h1234, 1'b0, 8'h00);
      n = 1;
      @(posedge clk);
      while (cpu_ack !== 1'b1)
      begin
        @(posedge clk);
        n++;
      end
      chk(8'hA5, cpu_rdata);
      chk((i == 0) ? 32'h5 : 32'h3, n);
      cpu_req <= '0;
    end
  endtask
  task automatic t_scratch;
    mmsl_req_t r;
    acc(rq(MMSL_SP_IDIR, 16'h0010, 1'b1, 8'h3C), 8'h00, 1'b0);
    acc(rq(MMSL_SP_IIND, 16'h0010, 1'b0, 8'h00), 8'h3C, 1'b0);
    acc(rq(MMSL_SP_IIND, 16'h0090, 1'b1, 8'h5A), 8'h00, 1'b0);
    acc(rq(MMSL_SP_IDIR, 16'h0090, 1'b0, 8'h00), 8'h77, 1'b0);
    acc(rq(MMSL_SP_IIND, 16'h0090, 1'b0, 8'h00), 8'h5A, 1'b0);
    acc(rq(MMSL_SP_IDIR, 16'h0021, 1'b1, 8'h00), 8'h00, 1'b0);
    r = rq(MMSL_SP_IDIR, 16'h0021, 1'b1, 8'h00);
    r.bit_op = 1'b1;
    r.bit_sel = 3'h3;
    r.bit_fn = 2'h1;
    acc(r, 8'h00, 1'b0);
    acc(rq(MMSL_SP_IDIR, 16'h0021, 1'b0, 8'h00), 8'h08, 1'b0);
    r.wr = 1'b0;
    acc(r, 8'h01, 1'b0);
    r.wr = 1'b1;
    r.bit_fn = 2'h0;
    acc(r, 8'h00, 1'b0);
    acc(rq(MMSL_SP_IDIR, 16'h0021, 1'b0, 8'h00), 8'h00, 1'b0);
    stack_op <= 1'b1;
    sp_reg <= 8'h09;
    acc(rq(MMSL_SP_IIND, 16'h0000, 1'b1, 8'h66), 8'h00, 1'b0);
    stack_op <= 1'b0;
    acc(rq(MMSL_SP_IDIR, 16'h0009, 1'b0, 8'h00), 8'h66, 1'b0);
    reg_op_en <= 1'b1;
    bank_sel <= 2'h2;
    reg_op <= 3'h3;
    acc(rq(MMSL_SP_IDIR, 16'h0000, 1'b1, 8'h99), 8'h00, 1'b0);
    reg_op_en <= 1'b0;
    acc(rq(MMSL_SP_IDIR, 16'h0013, 1'b0, 8'h00), 8'h99, 1'b0);
  endtask
  task automatic t_levels;
    mmsl_req_t r;
    logic [31:0] q;
    rst(3'h7, 8'h0F);
    ver(~(8'h3C ^ 8'h0F));
    chk(1'b1, prog_allow);
    rst(3'h6, 8'hFF);
    ver(8'h3C);
    chk(1'b0, prog_allow);
    r = rq(MMSL_SP_CODE, 16'h0010, 1'b0, 8'h00);
    r.from_ext = 1'b1;
    r.table_read = 1'b1;
    acc(r, 8'hFF, 1'b1);
    avs(1'b0, 8'h08, 32'h0, q);
    chk(3'h6, q[5:3]);
    rst(3'h5, 8'hFF);
    ver(8'hFF);
    r = rq(MMSL_SP_XDATA, 16'h0100, 1'b0, 8'h00);
    r.from_ext = 1'b1;
    acc(r, 8'hFF, 1'b1);
    r.space = MMSL_SP_CODE;
    r.table_read = 1'b1;
    acc(r, 8'hFF, 1'b1);
    rst(3'h3, 8'hFF);
    acc(rq(MMSL_SP_CODE, 16'hC034, 1'b0, 8'h00), 8'hFF, 1'b1);
    ver(8'hFF);
  endtask
  initial
  begin
    rst(3'h7, 8'hFF);
    t_regs();
    t_ext();
    t_page();
    t_scratch();
    t_levels();
    give_verdict();
  end
endmodule
bind mmsl_top mmsl_properties chk_u (.clk, .rst_b, .avs_address, .avs_read, .avs_readdata, .avs_waitrequest,
  .cpu_req, .stack_op, .reg_op_en, .cpu_ack, .sfr_sel, .ext_bus, .sec_lock_bits, .sec_key_byte, .flash_rdata,
  .verify_data, .verify_ack, .prog_allow);
